//--- trt_consts.vh
`ifndef TRT_CONSTS_VH
`define TRT_CONSTS_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define TRT_ADDR_PIN_FUNC      8'h00
`define TRT_ADDR_RUN_CTRL      8'h04
`define TRT_ADDR_CAPTURE       8'h3C
// Channel n occupies 0x10*(n+1) .. 0x10*(n+1)+0x0B
`define TRT_CH_BASE_0          4'h1
`define TRT_CH_BASE_2          4'h3
`define TRT_CH_RELOAD          2'h0
`define TRT_CH_COUNTER         2'h1
`define TRT_CH_CONTROL         2'h2

// ****************************************************************
// Field positions
// ****************************************************************
`define TRT_PFC_OUT_SEL        0
`define TRT_CTL_UF_FLAG        8
`define TRT_CTL_CAP_FLAG       9
`define TRT_CTL_CAP_EN         6
`define TRT_CTL_UF_IRQ_EN      5
`define TRT_CTL_EDGE_HI        4
`define TRT_CTL_EDGE_LO        3
`define TRT_CTL_CLK_HI         2
`define TRT_CTL_CLK_LO         0

// ****************************************************************
// Encodings and masks
// ****************************************************************
`define TRT_CLK_DIV4           3'h0
`define TRT_CLK_DIV16          3'h1
`define TRT_CLK_DIV64          3'h2
`define TRT_CLK_DIV256         3'h3
`define TRT_CLK_RTC            3'h4
`define TRT_CLK_EXT            3'h5
`define TRT_CTL_WMASK_BASIC    8'h3F
`define TRT_CTL_WMASK_CAPT     8'h7F

// ****************************************************************
// Reset values and responses
// ****************************************************************
`define TRT_RST_BYTE           8'h00
`define TRT_RST_WORD           32'h0000_0000
`define TRT_RESP_OKAY          2'h0
`define TRT_RESP_SLVERR        2'h2

`endif

//--- trt_channel.v
`timescale 1ns/100ps
`include "trt_consts.vh"

module trt_channel #(
  parameter HAS_CAPTURE = 0
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Count sources
  input  wire [3:0]  presc_tick,
  input  wire        rtc_tick,
  input  wire        ext_rise,
  input  wire        ext_fall,
  input  wire        run,
  // Register writes
  input  wire        ctrl_we,
  input  wire [15:0] ctrl_wdata,
  input  wire        cnt_we,
  input  wire [31:0] cnt_wdata,
  input  wire        reload_we,
  input  wire [31:0] reload_wdata,
  // State
  output wire [31:0] counter,
  output wire [31:0] reload,
  output wire [15:0] ctrl,
  output wire [31:0] capture_value,
  output wire        irq
);

  reg  [31:0] cnt_reg;
  reg  [31:0] reload_reg;
  reg  [7:0]  field_reg;
  reg         uf_flag_reg;
  reg         cap_flag_reg;
  reg  [31:0] capture_reg;
  reg         irq_reg;
  reg         tick;
  wire [7:0]  wmask;
  wire        ext_edge;
  wire        count;
  wire        underflow;
  wire        cap_evt;
  wire        uf_next;

  assign wmask = HAS_CAPTURE ? `TRT_CTL_WMASK_CAPT : `TRT_CTL_WMASK_BASIC;

  assign ext_edge = ctrl[`TRT_CTL_EDGE_HI] ? (ext_rise | ext_fall) :
                    ctrl[`TRT_CTL_EDGE_LO] ? ext_fall : ext_rise;

  // ****************************************************************
  // Count clock select
  // ****************************************************************
  // six count sources
  always @*
  begin
    case (field_reg[`TRT_CTL_CLK_HI:`TRT_CTL_CLK_LO])
      `TRT_CLK_DIV4:   tick = presc_tick[0];
      `TRT_CLK_DIV16:  tick = presc_tick[1];
      `TRT_CLK_DIV64:  tick = presc_tick[2];
      `TRT_CLK_DIV256: tick = presc_tick[3];
      `TRT_CLK_RTC:    tick = rtc_tick;
      `TRT_CLK_EXT:    tick = ext_edge;
      default:         tick = 1'b0;
    endcase
  end

  assign count     = run & tick;
  assign underflow = count & (cnt_reg == `TRT_RST_WORD);
  assign cap_evt   = (HAS_CAPTURE != 0) & field_reg[`TRT_CTL_CAP_EN] & ext_edge;
  assign uf_next   = underflow |
                     (uf_flag_reg & (~ctrl_we | ctrl_wdata[`TRT_CTL_UF_FLAG]));

  // ****************************************************************
  // Counter, reload and flags
  // ****************************************************************
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_reg      <= `TRT_RST_WORD;
      reload_reg   <= `TRT_RST_WORD;
      field_reg    <= `TRT_RST_BYTE;
      uf_flag_reg  <= 1'b0;
      cap_flag_reg <= 1'b0;
      capture_reg  <= `TRT_RST_WORD;
      irq_reg      <= 1'b0;
    end
    else
    begin
      if (cnt_we)
        cnt_reg <= cnt_wdata;
      else if (underflow)
        cnt_reg <= reload_reg;
      else if (count)
        cnt_reg <= cnt_reg - 32'h0000_0001;
      if (reload_we)
        reload_reg <= reload_wdata;
      if (ctrl_we)
        field_reg <= ctrl_wdata[7:0] & wmask;
      uf_flag_reg <= uf_next;
      if (cap_evt)
        capture_reg <= cnt_reg;
      cap_flag_reg <= cap_evt | (cap_flag_reg &
                      (~ctrl_we | ctrl_wdata[`TRT_CTL_CAP_FLAG]));
      irq_reg <= uf_next & field_reg[`TRT_CTL_UF_IRQ_EN];
    end
  end

  assign counter       = cnt_reg;
  assign reload        = reload_reg;
  assign ctrl          = {6'h00, cap_flag_reg, uf_flag_reg, field_reg};
  assign capture_value = capture_reg;
  assign irq           = irq_reg;

endmodule

//--- trt_timer_unit.v
// Summary of operation
// - Each of three channels has a 32-bit auto-reloading down counter.
// - Underflow at zero reloads the counter and raises the channel's underflow flag.
// - Reload constant and counter are readable and writable while counting.
// - Channel 2 alone captures its counter on a shared pin edge.
// - Count clock is pin, RTC clock, or peripheral clock /4 /16 /64 /256.
// - Channels on the RTC clock keep counting in standby.
// - Counter reads return a consistent 32-bit snapshot.
// - One bit makes the shared pin an input or the RTC clock output.
// - Software sets the pin's port function to 00 before use.
// - Pin function register resets to zero and survives standby.
// - Run bits 0, 1, 2 run or halt channels 0, 1, 2.
// - Run register resets to zero; RTC-clocked run bits survive standby.
// - Standby, ratio change or module stop clear non-RTC run bits.
// - Reserved bits of both byte registers read as zero.
// - Clock select 000-011 prescaler, 100 RTC, 101 pin; 11x no count.
// - Underflow flag at bit 8 sets on underflow, clears on written 0.
// - Enable at bit 5 passes the underflow flag as a request.
// - Edge select 00 rising, 01 falling, 1x both edges.
//
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "trt_consts.vh"

module trt_timer_unit (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // System events
  input  wire        standby,
  input  wire        pll_ratio_change,
  input  wire        module_stop_bit,
  // Clock from the real-time clock
  input  wire        rtc_output_clock,
  // Shared timer pin
  input  wire        shared_timer_pin_in,
  output wire        shared_timer_pin_out,
  output wire        shared_timer_pin_oe,
  // Interrupt requests
  output wire [2:0]  underflow_interrupt
);

  // ****************************************************************
  // Bus slave state
  // ****************************************************************
  reg  [7:0]  aw_addr_reg;
  reg         aw_full_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  reg         w_full_reg;
  reg         awready_reg;
  reg         wready_reg;
  reg         bvalid_reg;
  reg  [1:0]  bresp_reg;
  reg         arready_reg;
  reg         rvalid_reg;
  reg  [31:0] rdata_reg;
  reg  [1:0]  rresp_reg;
  reg         aw_full_next;
  reg         w_full_next;

  // ****************************************************************
  // Timer state
  // ****************************************************************
  reg  [7:0]  pin_function_control_reg;
  reg  [7:0]  run_control_reg;
  reg  [7:0]  presc_reg;
  reg  [3:0]  presc_tick_reg;
  reg         pin_q_reg;
  reg         pin_prev_reg;
  reg         rtc_q_reg;
  reg         rtc_prev_reg;
  reg         pin_out_reg;
  reg         pin_oe_reg;
  reg         standby_prev_reg;
  reg         mstop_prev_reg;
  reg  [2:0]  run_next;
  reg  [31:0] rd_mux;
  reg         rd_hit;
  reg         wr_hit;

  wire        wr_go;
  wire        stop_event;
  wire        ext_en;
  wire        rtc_tick;
  wire        ext_rise;
  wire        ext_fall;
  wire [1:0]  ch_sel_w;
  wire [1:0]  ch_sel_r;
  wire [31:0] cnt_w    [0:2];
  wire [31:0] reload_w [0:2];
  wire [15:0] ctrl_w   [0:2];
  wire [31:0] cap_w    [0:2];
  wire [2:0]  irq_w;

  function [31:0] trt_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer      i;
    begin
      trt_merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          trt_merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  assign wr_go    = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign ch_sel_w = aw_addr_reg[5:4] - 2'h1;
  assign ch_sel_r = s_axi_araddr[5:4] - 2'h1;

  // ****************************************************************
  // Write channel
  // ****************************************************************
  always @*
  begin
    aw_full_next = aw_full_reg;
    w_full_next  = w_full_reg;
    if (s_axi_awvalid && awready_reg)
      aw_full_next = 1'b1;
    if (s_axi_wvalid && wready_reg)
      w_full_next = 1'b1;
    if (wr_go)
    begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
    end
  end

  always @*
  begin
    wr_hit = 1'b0;
    if (aw_addr_reg[1:0] == 2'h0)
    begin
      if (aw_addr_reg == `TRT_ADDR_PIN_FUNC ||
          aw_addr_reg == `TRT_ADDR_RUN_CTRL ||
          aw_addr_reg == `TRT_ADDR_CAPTURE)
        wr_hit = 1'b1;
      else if (aw_addr_reg[7:4] >= `TRT_CH_BASE_0 &&
               aw_addr_reg[7:4] <= `TRT_CH_BASE_2 &&
               aw_addr_reg[3:2] != 2'h3)
        wr_hit = 1'b1;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_addr_reg <= `TRT_RST_BYTE;
      aw_full_reg <= 1'b0;
      w_data_reg  <= `TRT_RST_WORD;
      w_strb_reg  <= 4'h0;
      w_full_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `TRT_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && awready_reg)
        aw_addr_reg <= s_axi_awaddr;
      if (s_axi_wvalid && wready_reg)
      begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      awready_reg <= ~aw_full_next;
      wready_reg  <= ~w_full_next;
      if (wr_go)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? `TRT_RESP_OKAY : `TRT_RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  // reserved bits read zero
  always @*
  begin
    rd_mux = `TRT_RST_WORD;
    rd_hit = 1'b0;
    if (s_axi_araddr[1:0] == 2'h0)
    begin
      if (s_axi_araddr == `TRT_ADDR_PIN_FUNC)
      begin
        rd_mux = {31'h0000_0000, pin_function_control_reg[0]};
        rd_hit = 1'b1;
      end
      else if (s_axi_araddr == `TRT_ADDR_RUN_CTRL)
      begin
        rd_mux = {29'h0000_0000, run_control_reg[2:0]};
        rd_hit = 1'b1;
      end
      else if (s_axi_araddr == `TRT_ADDR_CAPTURE)
      begin
        rd_mux = cap_w[2];
        rd_hit = 1'b1;
      end
      else if (s_axi_araddr[7:4] >= `TRT_CH_BASE_0 &&
               s_axi_araddr[7:4] <= `TRT_CH_BASE_2)
      begin
        rd_hit = 1'b1;
        case (s_axi_araddr[3:2])
          `TRT_CH_RELOAD:  rd_mux = reload_w[ch_sel_r];
          `TRT_CH_COUNTER: rd_mux = cnt_w[ch_sel_r];
          `TRT_CH_CONTROL: rd_mux = {16'h0000, ctrl_w[ch_sel_r]};
          default:         rd_hit = 1'b0;
        endcase
      end
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= `TRT_RST_WORD;
      rresp_reg   <= `TRT_RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_reg)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_mux;
      rresp_reg   <= rd_hit ? `TRT_RESP_OKAY : `TRT_RESP_SLVERR;
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
    else if (!rvalid_reg)
      arready_reg <= 1'b1;
  end

  // ****************************************************************
  // Prescaler, pin and run control
  // ****************************************************************
  assign stop_event = (standby & ~standby_prev_reg) | pll_ratio_change |
                      (module_stop_bit & ~mstop_prev_reg);
  // input role only when not driving
  assign ext_en   = ~pin_function_control_reg[`TRT_PFC_OUT_SEL];
  assign ext_rise = ext_en & pin_q_reg & ~pin_prev_reg;
  assign ext_fall = ext_en & ~pin_q_reg & pin_prev_reg;
  assign rtc_tick = rtc_q_reg & ~rtc_prev_reg;

  always @*
  begin
    run_next = run_control_reg[2:0];
    if (wr_go && aw_addr_reg == `TRT_ADDR_RUN_CTRL && w_strb_reg[0])
      run_next = w_data_reg[2:0];
    if (stop_event)
      run_next = run_next & {ctrl_w[2][2:0] == `TRT_CLK_RTC,
                             ctrl_w[1][2:0] == `TRT_CLK_RTC,
                             ctrl_w[0][2:0] == `TRT_CLK_RTC};
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_function_control_reg <= `TRT_RST_BYTE;
      run_control_reg  <= `TRT_RST_BYTE;
      presc_reg        <= `TRT_RST_BYTE;
      presc_tick_reg   <= 4'h0;
      pin_q_reg        <= 1'b0;
      pin_prev_reg     <= 1'b0;
      rtc_q_reg        <= 1'b0;
      rtc_prev_reg     <= 1'b0;
      pin_out_reg      <= 1'b0;
      pin_oe_reg       <= 1'b0;
      standby_prev_reg <= 1'b0;
      mstop_prev_reg   <= 1'b0;
    end
    else
    begin
      if (wr_go && aw_addr_reg == `TRT_ADDR_PIN_FUNC && w_strb_reg[0])
        pin_function_control_reg <= {7'h00, w_data_reg[`TRT_PFC_OUT_SEL]};
      run_control_reg <= {5'h00, run_next};
      if (!standby)
        presc_reg <= presc_reg + 8'h01;
      presc_tick_reg <= {8'h00 == ~presc_reg[7:0],
                         6'h00 == ~presc_reg[5:0],
                         4'h0 == ~presc_reg[3:0],
                         2'h0 == ~presc_reg[1:0]} & {4{~standby}};
      pin_q_reg        <= shared_timer_pin_in;
      pin_prev_reg     <= pin_q_reg;
      rtc_q_reg        <= rtc_output_clock;
      rtc_prev_reg     <= rtc_q_reg;
      pin_out_reg      <= rtc_q_reg & ~ext_en;
      pin_oe_reg       <= ~ext_en;
      standby_prev_reg <= standby;
      mstop_prev_reg   <= module_stop_bit;
    end
  end

  // ****************************************************************
  // Channels
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : gen_ch
      localparam [1:0] CH_IDX = g;
      wire [31:0] ctrl_merged;
      wire sel = wr_go && (aw_addr_reg[1:0] == 2'h0) &&
                 (ch_sel_w == CH_IDX) &&
                 (aw_addr_reg[7:4] >= `TRT_CH_BASE_0) &&
                 (aw_addr_reg[7:4] <= `TRT_CH_BASE_2);
      assign ctrl_merged = trt_merge({16'h0000, ctrl_w[g]}, w_data_reg,
                                     w_strb_reg);
      trt_channel #(
        .HAS_CAPTURE (g == 2)
      ) u_ch (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .presc_tick    (presc_tick_reg),
        .rtc_tick      (rtc_tick),
        .ext_rise      (ext_rise),
        .ext_fall      (ext_fall),
        .run           (run_control_reg[g]),
        .ctrl_we       (sel && aw_addr_reg[3:2] == `TRT_CH_CONTROL),
        .ctrl_wdata    (ctrl_merged[15:0]),
        .cnt_we        (sel && aw_addr_reg[3:2] == `TRT_CH_COUNTER),
        .cnt_wdata     (trt_merge(cnt_w[g], w_data_reg, w_strb_reg)),
        .reload_we     (sel && aw_addr_reg[3:2] == `TRT_CH_RELOAD),
        .reload_wdata  (trt_merge(reload_w[g], w_data_reg, w_strb_reg)),
        .counter       (cnt_w[g]),
        .reload        (reload_w[g]),
        .ctrl          (ctrl_w[g]),
        .capture_value (cap_w[g]),
        .irq           (irq_w[g])
      );
    end
  endgenerate

  assign s_axi_awready        = awready_reg;
  assign s_axi_wready         = wready_reg;
  assign s_axi_bvalid         = bvalid_reg;
  assign s_axi_bresp          = bresp_reg;
  assign s_axi_arready        = arready_reg;
  assign s_axi_rvalid         = rvalid_reg;
  assign s_axi_rdata          = rdata_reg;
  assign s_axi_rresp          = rresp_reg;
  assign shared_timer_pin_out = pin_out_reg;
  assign shared_timer_pin_oe  = pin_oe_reg;
  assign underflow_interrupt  = irq_w;

endmodule

//--- trt_timer_unit_sva.sv
`timescale 1ns/100ps
module trt_timer_unit_sva (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Register bus
  input wire [7:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // Pin, clock and requests
  input wire        rtc_output_clock,
  input wire        shared_timer_pin_out,
  input wire        shared_timer_pin_oe,
  input wire [2:0]  underflow_interrupt
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid
                 && s_axi_wready;
  wire rd_take = s_axi_arvalid && s_axi_arready;

  write_take_a : assert property (
    wr_take |=> (!s_axi_awready && !s_axi_wready) ##1 s_axi_bvalid)
    else $error("write answer late");
  write_done_a : assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer stuck");
  read_take_a : assert property (
    rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  read_done_a : assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read answer stuck");
  wr_unmapped_a : assert property (
    wr_take && s_axi_awaddr > 8'h3C |-> ##2 s_axi_bresp == 2'h2)
    else $error("unmapped write accepted");
  rd_unmapped_a : assert property (
    rd_take && s_axi_araddr > 8'h3C |=>
      s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read accepted");
  pin_quiet_a : assert property (
    !shared_timer_pin_oe |-> !shared_timer_pin_out)
    else $error("pin output while input");
  pin_follow_a : assert property (
    shared_timer_pin_oe && $rose(rtc_output_clock)
      |-> ##[1:3] shared_timer_pin_out)
    else $error("pin misses clock");
  irq_mask_a : assert property (
    wr_take && s_axi_awaddr == 8'h18 && !s_axi_wdata[5]
      |-> ##3 !underflow_interrupt[0])
    else $error("masked request raised");

  cover property ($rose(underflow_interrupt[0]));
  cover property (rd_take && s_axi_araddr > 8'h3C);
  cover property (shared_timer_pin_oe && shared_timer_pin_out);
endmodule

bind trt_timer_unit trt_timer_unit_sva u_sva (.*);

//--- trt_pin_model.sv
`timescale 1ns/100ps
module trt_pin_model #(
  parameter RTC_HALF = 50
) (
  // Clock
  input wire aclk,
  // Far side
  output reg rtc_output_clock,
  output reg pin_drive
);
  initial
  begin
    rtc_output_clock = 1'b0;
    pin_drive = 1'b0;
    forever
    begin
      repeat (RTC_HALF) @(posedge aclk);
      rtc_output_clock <= ~rtc_output_clock;
    end
  end

  task send_pulses(input integer cnt);
    integer p;
    begin
      for (p = 0; p < cnt; p = p + 1)
      begin
        pin_drive <= 1'b1;
        repeat (50) @(posedge aclk);
        pin_drive <= 1'b0;
        repeat (50) @(posedge aclk);
      end
    end
  endtask
endmodule

//--- tb_trt_timer_unit.sv
`timescale 1ns/100ps
`include "trt_consts.vh"
module tb_trt_timer_unit;
  localparam [7:0]  pin_a = `TRT_ADDR_PIN_FUNC;
  localparam [7:0]  run_a = `TRT_ADDR_RUN_CTRL;
  localparam [31:0] one   = 32'h0000_0001;
  reg         aclk = 1'b0, aresetn = 1'b0, standby = 1'b0;
  reg         pll_ratio_change = 1'b0, module_stop_bit = 1'b0;
  reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg  [31:0] s_axi_wdata = 32'h0000_0000;
  reg  [3:0]  s_axi_wstrb = 4'hF;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  reg         s_axi_arvalid = 1'b0, s_axi_bready = 1'b0;
  reg         s_axi_rready = 1'b0, okb;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire        s_axi_arready, s_axi_rvalid, rtc_output_clock, pin_drive;
  wire        shared_timer_pin_out, shared_timer_pin_oe;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [2:0]  underflow_interrupt;
  wire [31:0] irq0 = {31'b0, underflow_interrupt[0]};
  wire [31:0] oe32 = {31'b0, shared_timer_pin_oe};
  // Pin level from whichever side drives it
  wire        shared_timer_pin_in = shared_timer_pin_oe ?
                                    shared_timer_pin_out : pin_drive;
  integer     error_cnt = 0, checked = 0, n, i, e;
  reg  [31:0] v;
  reg  [1:0]  r, last_bresp;

  trt_timer_unit u_dut (.*);
  trt_pin_model u_pin (.aclk(aclk), .rtc_output_clock(rtc_output_clock),
                       .pin_drive(pin_drive));

  initial
  begin
    forever #2.5 aclk = ~aclk;
  end

  task summarize;
    begin
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  task hang;
    begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH wait expected answer seen none");
      summarize;
    end
  endtask

  task chk(input [31:0] seen, input [31:0] exp, input string nm);
    begin
      checked = checked + 1;
      if (seen !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  function [7:0] ca(input integer ch, input integer off);
    ca = 8'(16 * ch + 16 + 4 * off);
  endfunction

  task wr(input [7:0] a, input [31:0] d);
    integer k;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (k = 0; k < 60; k = k + 1)
      begin
        @(posedge aclk);
        if (s_axi_awready && s_axi_awvalid)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wready && s_axi_wvalid)
          s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid)
          break;
      end
      last_bresp = s_axi_bresp;
      if (k == 60)
        hang;
    end
  endtask

  task rd(input [7:0] a, output [31:0] d, output [1:0] rr);
    integer k;
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (k = 0; k < 60; k = k + 1)
      begin
        @(posedge aclk);
        if (s_axi_arready && s_axi_arvalid)
          s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid)
          break;
      end
      d = s_axi_rdata;
      rr = s_axi_rresp;
      if (k == 60)
        hang;
    end
  endtask

  task rc(input [7:0] a, input [31:0] exp, input string nm);
    begin
      rd(a, v, r);
      chk(v, exp, nm);
    end
  endtask

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    s_axi_bready <= 1'b1;
    s_axi_rready <= 1'b1;
    repeat (2) @(posedge aclk);
    for (i = 0; i < 9; i = i + 1)
      rc(ca(i / 3, i % 3), 32'h0000_0000, "reset");
    rc(pin_a, 32'h0000_0000, "pin reset");
    rc(run_a, 32'h0000_0000, "run reset");
    wr(pin_a, 32'hFFFF_FFFF);
    rc(pin_a, one, "pin rsvd");
    chk(oe32, one, "pin out");
    repeat (150) @(posedge aclk);
    wr(pin_a, 32'h0000_0000);
    repeat (3) @(posedge aclk);
    chk(oe32, 32'h0000_0000, "pin in");
    wr(run_a, 32'hFFFF_FFF8);
    rc(run_a, 32'h0000_0000, "run rsvd");
    wr(ca(0, 2), 32'hFFFF_FFFF);
    rc(ca(0, 2), 32'h0000_003F, "ctl0 rsvd");
    wr(ca(2, 2), 32'hFFFF_FFFF);
    rc(ca(2, 2), 32'h0000_007F, "ctl2 rsvd");
    wr(8'h40, one);
    chk({30'b0, last_bresp}, 32'h0000_0002, "bresp");
    rd(8'h40, v, r);
    chk({30'b0, r}, 32'h0000_0002, "rresp");
    chk(v, 32'h0000_0000, "rdata");
    // Underflow, reload and request
    wr(ca(0, 0), 32'h0000_0005);
    wr(ca(0, 1), 32'h0000_0002);
    wr(ca(0, 2), 32'h0000_0020);
    wr(run_a, one);
    for (n = 0; n < 200 && underflow_interrupt[0] !== 1'b1; n = n + 1)
      @(posedge aclk);
    if (n == 200)
      hang;
    wr(run_a, 32'h0000_0000);
    rd(ca(0, 1), v, r);
    okb = v <= 32'h0000_0005 && v >= 32'h0000_0002;
    chk({31'b0, okb}, one, "reload");
    rc(ca(0, 2), 32'h0000_0120, "flag set");
    wr(ca(0, 2), 32'h0000_0120);
    rc(ca(0, 2), 32'h0000_0120, "flag kept");
    chk(irq0, one, "irq on");
    wr(ca(0, 2), 32'h0000_0020);
    repeat (2) @(posedge aclk);
    chk(irq0, 32'h0000_0000, "irq off");
    wr(ca(0, 1), one);
    wr(ca(0, 2), 32'h0000_0000);
    wr(run_a, one);
    repeat (40) @(posedge aclk);
    wr(run_a, 32'h0000_0000);
    rc(ca(0, 2), 32'h0000_0100, "masked flag");
    chk(irq0, 32'h0000_0000, "irq mask");
    // Count rate for clock selects 000 to 100
    for (i = 0; i < 5; i = i + 1)
    begin
      wr(ca(1, 1), 32'h0000_03E8);
      wr(ca(1, 2), 32'(i));
      wr(run_a, 32'h0000_0002);
      repeat (1100) @(posedge aclk);
      wr(run_a, 32'h0000_0000);
      rd(ca(1, 1), v, r);
      e = (i < 4) ? (1100 >> (2 + 2 * i)) : 11;
      v = 32'h0000_03E8 - v;
      okb = v + 1 >= e && v <= e + 4;
      chk({31'b0, okb}, one, "rate");
    end
    // External pin with each edge select
    for (i = 0; i < 3; i = i + 1)
    begin
      wr(ca(1, 1), 32'h0000_0064);
      wr(ca(1, 2), 32'(5 + 8 * i));
      wr(run_a, 32'h0000_0002);
      u_pin.send_pulses(3);
      repeat (5) @(posedge aclk);
      wr(run_a, 32'h0000_0000);
      e = (i == 2) ? 32'h0000_005E : 32'h0000_0061;
      rc(ca(1, 1), 32'(e), "edges");
    end
    wr(ca(2, 1), 32'h1234_5678);
    wr(ca(2, 2), 32'h0000_0040);
    u_pin.send_pulses(1);
    rc(`TRT_ADDR_CAPTURE, 32'h1234_5678, "capture");
    rc(ca(2, 2), 32'h0000_0240, "cap flag");
    rc(ca(2, 1), 32'h1234_5678, "halted");
    // Standby, ratio change and module stop
    wr(ca(0, 2), 32'h0000_0003);
    wr(ca(1, 2), 32'h0000_0004);
    for (i = 0; i < 3; i = i + 1)
    begin
      wr(ca(1, 1), 32'h0000_0400);
      wr(run_a, 32'h0000_0003);
      standby <= (i == 0);
      pll_ratio_change <= (i == 1);
      module_stop_bit <= (i == 2);
      @(posedge aclk);
      pll_ratio_change <= 1'b0;
      repeat (300) @(posedge aclk);
      rc(run_a, 32'h0000_0002, "run kept");
      rd(ca(1, 1), v, r);
      okb = v < 32'h0000_0400 && v > 32'h0000_03F0;
      chk({31'b0, okb}, one, "rtc count");
      standby <= 1'b0;
      module_stop_bit <= 1'b0;
      wr(run_a, 32'h0000_0000);
    end
    summarize;
  end
endmodule
